// file: design/snr_front_end.sv
// two-wire slave front end: byte memory slave plus clock/alarm register slave
// assumes: scl/sda/backup pins are asynchronous; bus master drives scl; pull-ups external
module snr_front_end
	import snr_pkg::*;
#(
	parameter logic [6:0]  MEM_DEV_ID = 7'h50,  // arbitrary value
	parameter logic [6:0]  RTC_DEV_ID = 7'h68,  // arbitrary value
	parameter int unsigned MEM_DEPTH  = SNR_MEM_DEPTH,
	parameter int unsigned MEM_AW     = SNR_MEM_AW
)
(
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic scl_pin,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	input  wire logic crystal_in,
	input  wire logic backup_supply_pin,
	input  wire logic alarm_hit,
	output logic      alarm_cal_wave_output,
	output logic      alarm_cal_wave_oe
);

	// ========================================================
	// pin synchronisers
	logic scl_m_q, scl_s_q, scl_p_q;
	logic sda_m_q, sda_s_q, sda_p_q;
	logic bak_m_q, bak_s_q;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	// no reset here so the backup level is already settled inside reset
	always_ff @(posedge mclk) begin
		scl_m_q <= scl_pin;
		scl_s_q <= scl_m_q;
		scl_p_q <= scl_s_q;
		sda_m_q <= sda_in;
		sda_s_q <= sda_m_q;
		sda_p_q <= sda_s_q;
		bak_m_q <= backup_supply_pin;
		bak_s_q <= bak_m_q;
	end

	// bus events, all from the second flop onward
	assign scl_rise  = scl_s_q && !scl_p_q;
	assign scl_fall  = !scl_s_q && scl_p_q;
	assign bus_start = scl_s_q && scl_p_q && !sda_s_q && sda_p_q;
	assign bus_stop  = scl_s_q && scl_p_q && sda_s_q && !sda_p_q;

	// ========================================================
	// storage
	logic [7:0]            mem_q [MEM_DEPTH];
	logic [7:0]            sfr_q [SNR_SFR_NUM];
	logic                  mem_we;
	logic [MEM_AW-1:0]     mem_wa;
	logic                  sfr_we;
	logic [SNR_SFR_AW-1:0] sfr_wa;
	logic [7:0]            wr_byte;

	// nonvolatile array, no reset and no write delay
	always_ff @(posedge mclk) begin
		if (mem_we) begin
			mem_q[mem_wa] <= wr_byte;
		end
	end

	// register file; protect bits survive a reset while backup is present
	always_ff @(posedge mclk) begin
		for (int i = 0; i < SNR_SFR_NUM; i++) begin
			if (!nrst) begin
				if (i == int'(SNR_SFR_PROT) && bak_s_q) begin
					sfr_q[i] <= sfr_q[i] & SNR_PROT_KEEP_MASK;
				end else begin
					sfr_q[i] <= SNR_SFR_RESET;
				end
			end else if (sfr_we && sfr_wa == SNR_SFR_AW'(i)) begin
				sfr_q[i] <= wr_byte;
			end
		end
	end

	// ========================================================
	// decode of control fields
	logic [1:0] prot_sel;
	logic       cal_mode;
	logic       prot_hit;

	assign prot_sel = {sfr_q[SNR_SFR_PROT][SNR_PROT_HIGH_BIT],
	                   sfr_q[SNR_SFR_PROT][SNR_PROT_LOW_BIT]};
	assign cal_mode = sfr_q[SNR_SFR_CTRL][SNR_CTRL_CAL_BIT];

	// ========================================================
	// slave sequencer state
	snr_state_t            state_q, state_d;
	logic [3:0]            bitcnt_q, bitcnt_d;
	logic [7:0]            shift_q, shift_d;
	logic                  sda_oe_d;
	logic                  ack_q, ack_d;
	logic                  is_rtc_q, is_rtc_d;
	logic                  is_read_q, is_read_d;
	logic [1:0]            rx_idx_q, rx_idx_d;
	logic [MEM_AW-1:0]     mem_ptr_q, mem_ptr_d;
	logic [SNR_SFR_AW-1:0] rtc_ptr_q, rtc_ptr_d;
	logic [7:0]            byte_in;
	logic [7:0]            rd_byte;
	logic                  do_load;

	assign byte_in = {shift_q[6:0], sda_s_q};
	assign wr_byte = byte_in;
	assign rd_byte = is_rtc_q ? ((rtc_ptr_q <= SNR_SFR_LAST) ? sfr_q[rtc_ptr_q] : 8'h00)
	                          : mem_q[mem_ptr_q];

	// write protect window against the current pointer
	always_comb begin
		unique case (prot_sel)
			SNR_PROT_NONE:    prot_hit = 1'b0;
			SNR_PROT_QUARTER: prot_hit = 32'(mem_ptr_q) < (MEM_DEPTH / 4);
			SNR_PROT_HALF:    prot_hit = 32'(mem_ptr_q) < (MEM_DEPTH / 2);
			SNR_PROT_FULL:    prot_hit = 1'b1;
		endcase
	end

	// next-state logic for the slave
	always_comb begin
		state_d   = state_q;
		bitcnt_d  = bitcnt_q;
		shift_d   = shift_q;
		sda_oe_d  = sda_oe;
		ack_d     = ack_q;
		is_rtc_d  = is_rtc_q;
		is_read_d = is_read_q;
		rx_idx_d  = rx_idx_q;
		mem_ptr_d = mem_ptr_q;
		rtc_ptr_d = rtc_ptr_q;
		mem_we    = 1'b0;
		mem_wa    = mem_ptr_q;
		sfr_we    = 1'b0;
		sfr_wa    = rtc_ptr_q;
		do_load   = 1'b0;
		if (bus_stop) begin
			state_d  = SNR_ST_IDLE;
			sda_oe_d = 1'b0;
		end else if (bus_start) begin
			// repeated start also lands here, pointers kept
			state_d  = SNR_ST_DEVADDR;
			bitcnt_d = 4'h0;
			sda_oe_d = 1'b0;
		end else begin
			unique case (state_q)
				SNR_ST_IDLE: begin
				end
				SNR_ST_DEVADDR, SNR_ST_RX: begin
					if (scl_rise) begin
						shift_d  = byte_in;
						bitcnt_d = bitcnt_q + 4'h1;
					end
					if (scl_rise && bitcnt_q == 4'h7 && state_q == SNR_ST_DEVADDR) begin
						// one pin, two slaves told apart by id
						ack_d     = (byte_in[7:1] == MEM_DEV_ID) || (byte_in[7:1] == RTC_DEV_ID);
						is_rtc_d  = byte_in[7:1] == RTC_DEV_ID;
						is_read_d = byte_in[0];
						rx_idx_d  = 2'h0;
					end
					if (scl_rise && bitcnt_q == 4'h7 && state_q == SNR_ST_RX) begin
						ack_d = 1'b1;
						if (rx_idx_q != 2'h2) begin
							rx_idx_d = rx_idx_q + 2'h1;
						end
						if (is_rtc_q) begin
							if (rx_idx_q == 2'h0) begin
								rtc_ptr_d = byte_in[SNR_SFR_AW-1:0];
							end else begin
								// calibration value only open while calibrating
								sfr_we    = (rtc_ptr_q <= SNR_SFR_LAST) &&
								            (rtc_ptr_q != SNR_SFR_CAL || cal_mode);
								rtc_ptr_d = (rtc_ptr_q >= SNR_SFR_LAST) ? 4'h0 : rtc_ptr_q + 4'h1;
								rx_idx_d  = 2'h2;
							end
						end else if (rx_idx_q == 2'h0) begin
							mem_ptr_d = {byte_in[MEM_AW-9:0], mem_ptr_q[7:0]};
						end else if (rx_idx_q == 2'h1) begin
							mem_ptr_d = {mem_ptr_q[MEM_AW-1:8], byte_in};
						end else begin
							ack_d     = !prot_hit;
							mem_we    = !prot_hit;
							mem_ptr_d = mem_ptr_q + 1'b1;
						end
					end
					if (scl_fall && bitcnt_q == 4'h8) begin
						sda_oe_d = ack_q;
						state_d  = ack_q ? SNR_ST_ACK : SNR_ST_IDLE;
					end
				end
				SNR_ST_ACK: begin
					if (scl_fall) begin
						sda_oe_d = 1'b0;
						bitcnt_d = 4'h0;
						if (is_read_q) begin
							do_load = 1'b1;
						end else begin
							state_d = SNR_ST_RX;
						end
					end
				end
				SNR_ST_TX: begin
					if (scl_fall) begin
						if (bitcnt_q == 4'h8) begin
							sda_oe_d = 1'b0;
							state_d  = SNR_ST_MACK;
						end else begin
							shift_d  = {shift_q[6:0], 1'b0};
							sda_oe_d = !shift_q[6];
							bitcnt_d = bitcnt_q + 4'h1;
						end
					end
				end
				SNR_ST_MACK: begin
					if (scl_rise) begin
						ack_d = !sda_s_q;
					end
					if (scl_fall) begin
						if (ack_q) begin
							do_load = 1'b1;
						end else begin
							state_d = SNR_ST_IDLE;
						end
					end
				end
			endcase
		end
		// read byte fetch: first bit goes out on the same falling edge
		if (do_load) begin
			state_d  = SNR_ST_TX;
			shift_d  = rd_byte;
			sda_oe_d = !rd_byte[7];
			bitcnt_d = 4'h1;
			if (is_rtc_q) begin
				rtc_ptr_d = (rtc_ptr_q >= SNR_SFR_LAST) ? 4'h0 : rtc_ptr_q + 4'h1;
			end else begin
				mem_ptr_d = mem_ptr_q + 1'b1;
			end
		end
	end

	// registers of the slave; memory pointer held across clock transactions
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_q   <= SNR_ST_IDLE;
			bitcnt_q  <= 4'h0;
			shift_q   <= 8'h00;
			sda_oe    <= 1'b0;
			sda_out   <= 1'b0;
			ack_q     <= 1'b0;
			is_rtc_q  <= 1'b0;
			is_read_q <= 1'b0;
			rx_idx_q  <= 2'h0;
			mem_ptr_q <= '0;
			rtc_ptr_q <= 4'h0;
		end else begin
			state_q   <= state_d;
			bitcnt_q  <= bitcnt_d;
			shift_q   <= shift_d;
			sda_oe    <= sda_oe_d;
			sda_out   <= 1'b0;
			ack_q     <= ack_d;
			is_rtc_q  <= is_rtc_d;
			is_read_q <= is_read_d;
			rx_idx_q  <= rx_idx_d;
			mem_ptr_q <= mem_ptr_d;
			rtc_ptr_q <= rtc_ptr_d;
		end
	end

	// ========================================================
	// shared output pin
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			alarm_cal_wave_output <= 1'b0;
		end else begin
			alarm_cal_wave_output <= 1'b0;
		end
	end

	snr_wave_out u_wave (
		.mclk       (mclk),
		.nrst       (nrst),
		.crystal_in (crystal_in),
		.cal_mode   (cal_mode),
		.sqw_en     (sfr_q[SNR_SFR_PROT][SNR_PROT_SQW_BIT]),
		.freq_sel   (sfr_q[SNR_SFR_PROT][SNR_PROT_FSEL_LSB+1:SNR_PROT_FSEL_LSB]),
		.alarm_hit  (alarm_hit),
		.acs_oe     (alarm_cal_wave_oe)
	);

endmodule

// file: design/snr_wave_out.sv
// shared open-drain alarm / calibration / square-wave output stage
// assumes: crystal_in is a 32.768 kHz level from outside the mclk domain
module snr_wave_out
	import snr_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       crystal_in,
	input  wire logic       cal_mode,
	input  wire logic       sqw_en,
	input  wire logic [1:0] freq_sel,
	input  wire logic       alarm_hit,
	output logic            acs_oe
);

	// ========================================================
	// time base capture
	logic                 xt_m_q, xt_s_q, xt_p_q;
	logic [SNR_DIV_W-1:0] div_q, div_d;
	logic                 acs_oe_d;
	logic                 wave;

	// two flops before anything looks at the crystal level
	always_ff @(posedge mclk) begin
		xt_m_q <= crystal_in;
		xt_s_q <= xt_m_q;
		xt_p_q <= xt_s_q;
	end

	// ========================================================
	// divider and mode select
	always_comb begin
		div_d = div_q;
		if (xt_s_q && !xt_p_q) begin
			div_d = div_q + 1'b1;
		end
		unique case (freq_sel)
			SNR_FSEL_1HZ:   wave = div_q[SNR_DIV_BIT_1];
			SNR_FSEL_512HZ: wave = div_q[SNR_DIV_BIT_512];
			SNR_FSEL_4KHZ:  wave = div_q[SNR_DIV_BIT_4K];
			SNR_FSEL_32KHZ: wave = xt_s_q;
		endcase
		// calibration overrides everything, alarm is the fallback
		if (cal_mode) begin
			acs_oe_d = !div_q[SNR_DIV_BIT_512];
		end else if (sqw_en) begin
			acs_oe_d = !wave;
		end else begin
			acs_oe_d = alarm_hit;
		end
	end

	// pin only ever pulled low or released
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			div_q  <= '0;
			acs_oe <= 1'b0;
		end else begin
			div_q  <= div_d;
			acs_oe <= acs_oe_d;
		end
	end

endmodule

// file: dv/snr_bus_master.sv
// two-wire bus master model: drives the serial clock and pulls data low
// assumes: the bench resolves the data line with a pull-up
module snr_bus_master (
	input  wire logic mclk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_pull
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// clock idles high and stands still between frames
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// data moves 2 mclk after a clock fall, so no false start or stop is seen
	task automatic start();
		w(2);
		sda_pull = 1'b0;
		w(6);
		scl = 1'b1;
		w(8);
		sda_pull = 1'b1;
		w(8);
		scl = 1'b0;
	endtask
	task automatic stop();
		w(2);
		sda_pull = 1'b1;
		w(6);
		scl = 1'b1;
		w(8);
		sda_pull = 1'b0;
		w(8);
	endtask
	// eight bits msb first, then the ninth; returns what the line carried
	task automatic xfer(input logic [7:0] tx, input logic nin, output logic [7:0] rx,
		output logic nrx);
		logic [8:0] b;
		b = {tx, nin};
		for (int i = 8; i >= 0; i--) begin
			w(2);
			sda_pull = !b[i];
			w(6);
			scl = 1'b1;
			w(8);
			b[i] = sda_line;
			scl = 1'b0;
		end
		rx = b[8:1];
		nrx = b[0];
	endtask
endmodule

// file: dv/snr_front_end_sva.sv
// port checker of the two-wire front end, bound at the foot
// assumes: every port sampled on mclk, reset synchronous active low
module snr_front_end_sva (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic scl_pin,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic alarm_hit,
	input wire logic alarm_cal_wave_output,
	input wire logic alarm_cal_wave_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic [3:0] nbits_q, nbits_d, age_q, age_d;
	logic       scl_q, sda_q, al_q;
	// ==========
	// bits since start, cycles since the alarm input last moved
	always_comb begin
		nbits_d = nbits_q;
		if (scl_q && scl_pin && sda_q && !sda_in)
			nbits_d = 4'h0;
		else if (!scl_q && scl_pin && nbits_q != 4'hf)
			nbits_d = nbits_q + 4'h1;
		age_d = (age_q == 4'hf) ? age_q : age_q + 4'h1;
		if (al_q != alarm_hit)
			age_d = 4'h0;
	end
	always_ff @(posedge mclk) begin
		nbits_q <= nrst ? nbits_d : 4'h0;
		age_q <= nrst ? age_d : 4'hf;
		scl_q <= scl_pin;
		sda_q <= sda_in;
		al_q <= alarm_hit;
	end
	// ==========
	// pins
	a_sda_pull_only: assert property (sda_oe |-> !sda_out)
		else $error("data line driven high");
	a_acs_pull_only: assert property (alarm_cal_wave_oe |-> !alarm_cal_wave_output)
		else $error("shared pin driven high");
	a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_pin && !$past(scl_pin))
		else $error("data moved while clock high");
	a_sda_fall_lag: assert property ($changed(sda_oe) |-> $past(scl_pin, 3) ||
		$past(scl_pin, 4) || $past(scl_pin, 5) || $past(scl_pin, 6))
		else $error("data moved late after clock fall");
	a_sda_bit_hold: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*8])
		else $error("data bit too short");
	a_stop_release: assert property (scl_pin && $past(scl_pin) && $rose(sda_in)
		|=> !sda_oe [*8])
		else $error("data pulled after stop");
	a_addr_first: assert property ($rose(sda_oe) |-> nbits_q >= 4'h8)
		else $error("drive before address byte");
	// one cycle after an alarm move the pin follows it; limitation: the bench moves
	// the alarm only while the pin is in alarm mode
	a_acs_cause: assert property (age_q == 4'h0 |-> alarm_cal_wave_oe == al_q)
		else $error("shared pin did not follow alarm");
	c_ack: cover property ($rose(sda_oe));
	c_acs: cover property ($rose(alarm_cal_wave_oe));
	c_stop: cover property (scl_pin && $rose(sda_in));
endmodule

bind snr_front_end snr_front_end_sva snr_front_end_sva_inst (.mclk(mclk), .nrst(nrst),
	.scl_pin(scl_pin), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.alarm_hit(alarm_hit), .alarm_cal_wave_output(alarm_cal_wave_output),
	.alarm_cal_wave_oe(alarm_cal_wave_oe));

// file: dv/snr_front_end_tb.sv
// self-checking bench of the two-wire memory/clock front end
// assumes: master model on the serial pins; crystal sped up to keep the run short
module snr_front_end_tb
	import snr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] MEM_ID = 7'h50; // arbitrary value
	localparam logic [6:0] RTC_ID = 7'h68; // arbitrary value
	logic        mclk = 1'b0, nrst = 1'b0, crystal_in = 1'b0;
	logic        backup_supply_pin = 1'b0, alarm_hit = 1'b0;
	logic        sda_out, sda_oe, acs_out, acs_oe, ack9;
	logic [7:0]  rx;
	wire logic   scl, m_pull;
	wire logic   sda_line = !(sda_oe || m_pull);
	int          errors = 0, checked = 0;
	integer      seed = 32'he113ef53;
	// ==========
	// clocks: mclk 4 ns, crystal 40 ns
	always #2 mclk = ~mclk;
	always begin
		repeat (5) @(negedge mclk);
		crystal_in = ~crystal_in;
	end
	snr_front_end #(.MEM_DEV_ID(MEM_ID), .RTC_DEV_ID(RTC_ID)) snr_front_end_inst (
		.mclk(mclk), .nrst(nrst), .scl_pin(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .crystal_in(crystal_in), .backup_supply_pin(backup_supply_pin),
		.alarm_hit(alarm_hit), .alarm_cal_wave_output(acs_out), .alarm_cal_wave_oe(acs_oe));
	snr_bus_master snr_bus_master_inst (.mclk(mclk), .sda_line(sda_line), .scl(scl),
		.sda_pull(m_pull));
	// ==========
	// helpers
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	function automatic int lim(input int p);
		return p == 0 ? 0 : 1024 << p;
	endfunction
	task automatic st();
		snr_bus_master_inst.start();
	endtask
	task automatic sp();
		snr_bus_master_inst.stop();
	endtask
	// ack9 comes back high when the byte was acknowledged
	task automatic put(input logic [7:0] b);
		snr_bus_master_inst.xfer(b, 1'b1, rx, ack9);
		ack9 = !ack9;
	endtask
	task automatic get(input logic last);
		snr_bus_master_inst.xfer(8'hff, last, rx, ack9);
	endtask
	task automatic seta(input logic [12:0] a);
		st();
		put({MEM_ID, 1'b0});
		put({3'h0, a[12:8]});
		put(a[7:0]);
	endtask
	task automatic mwr(input logic [12:0] a, input logic [7:0] v);
		seta(a);
		put(v);
		sp();
	endtask
	task automatic mrd(input logic [12:0] a);
		seta(a);
		st();
		put({MEM_ID, 1'b1});
		get(1'b1);
		sp();
	endtask
	task automatic rwr(input logic [3:0] i, input logic [7:0] v);
		st();
		put({RTC_ID, 1'b0});
		put({4'h0, i});
		put(v);
		chk("register ack", 8'h1, 8'(ack9));
		sp();
	endtask
	// set the register index, then read one byte back after a repeated start
	task automatic rrd(input logic [3:0] i);
		st();
		put({RTC_ID, 1'b0});
		put({4'h0, i});
		st();
		put({RTC_ID, 1'b1});
		get(1'b1);
		sp();
	endtask
	task automatic do_reset(input logic bk);
		// backup level settles before reset so kept protect bits are not lost
		backup_supply_pin = bk;
		if (nrst)
			repeat (4) @(negedge mclk);
		nrst = 1'b0;
		repeat (12) @(negedge mclk);
		nrst = 1'b1;
		repeat (8) @(negedge mclk);
	endtask
	task automatic rises(output int n);
		logic prev;
		n = 0;
		repeat (40) @(negedge mclk);
		prev = acs_oe;
		repeat (5120) begin
			@(negedge mclk);
			if (acs_oe && !prev)
				n++;
			prev = acs_oe;
		end
	endtask
	// ==========
	// watchdog, sized above the expected 62k cycles and under the run limit
	initial begin
		repeat (90000) @(posedge mclk);
		errors++;
		finish_test();
	end
	// ==========
	// main sequence
	initial begin
		logic [7:0]  d [4];
		logic [7:0]  mm [4];
		logic [12:0] pa [4];
		logic [7:0]  pr [6];
		int          ex [6];
		int          n;
		pa = '{13'h07ff, 13'h0800, 13'h0fff, 13'h1000};
		pr = '{8'h80, 8'ha0, 8'hc0, 8'he0, 8'he0, 8'he0};
		ex = '{0, 8, 64, 512, 8, 512};
		do_reset(1'b0);
		// random burst across the top of the array, read back at once
		seta(13'h1ffe);
		for (int i = 0; i < 4; i++) begin
			d[i] = 8'($random(seed));
			put(d[i]);
			chk("write ack", 8'h1, 8'(ack9));
		end
		sp();
		seta(13'h1ffe);
		st();
		put({MEM_ID, 1'b1});
		for (int i = 0; i < 3; i++) begin
			get(i == 2);
			chk("read data", d[i], rx);
		end
		sp();
		rwr(SNR_SFR_CTRL, 8'h00);
		st();
		put({MEM_ID, 1'b1});
		get(1'b1);
		chk("pointer kept", d[3], rx);
		sp();
		st();
		put({7'h2a, 1'b0});
		chk("foreign id", 8'h0, 8'(ack9));
		sp();
		// calibration value locked unless calibrating; nothing past the last register
		rwr(SNR_SFR_CAL, 8'h15);
		rrd(SNR_SFR_CAL);
		chk("cal locked", SNR_SFR_RESET, rx);
		rwr(SNR_SFR_CTRL, 8'h04);
		rwr(SNR_SFR_CAL, 8'h15);
		rrd(SNR_SFR_CAL);
		chk("cal open", 8'h15, rx);
		rwr(SNR_SFR_CTRL, 8'h00);
		rwr(4'hf, 8'h33);
		rrd(4'hf);
		chk("no sixteenth register", 8'h00, rx);
		$display("test memory and ids done");
		// every protect setting against both sides of each boundary
		for (int p = 0; p < 4; p++) begin
			rwr(SNR_SFR_PROT, 8'(p << 3));
			for (int k = 0; k < 4; k++) begin
				n = int'(pa[k]) >= lim(p);
				d[0] = 8'($random(seed));
				mwr(pa[k], d[0]);
				chk("protect ack", 8'(n), 8'(ack9));
				if (n != 0)
					mm[k] = d[0];
			end
		end
		rwr(SNR_SFR_PROT, 8'h00);
		for (int k = 0; k < 4; k++) begin
			mrd(pa[k]);
			chk("protected data", mm[k], rx);
		end
		rwr(SNR_SFR_PROT, 8'h18);
		do_reset(1'b1);
		mwr(13'h1000, 8'h5a);
		chk("backup keeps protect", 8'h0, 8'(ack9));
		do_reset(1'b0);
		mwr(13'h1000, 8'h5a);
		chk("power-up clears", 8'h1, 8'(ack9));
		$display("test protection done");
		// shared pin: alarm, then wave rates, calibration over square wave
		alarm_hit = 1'b1;
		repeat (12) @(negedge mclk);
		chk("alarm low", 8'h1, 8'(acs_oe));
		chk("drive levels", 8'h0, {6'h0, sda_out, acs_out});
		alarm_hit = 1'b0;
		repeat (12) @(negedge mclk);
		chk("alarm off", 8'h0, 8'(acs_oe));
		for (int j = 0; j < 6; j++) begin
			rwr(SNR_SFR_PROT, pr[j]);
			rwr(SNR_SFR_CTRL, (j == 4) ? 8'h04 : 8'h00);
			rises(n);
			chk("wave rate", 8'h1, 8'(n >= ex[j] - 1 && n <= ex[j] + 1));
		end
		$display("test shared pin done");
		finish_test();
	end
endmodule

// file: include/snr_pkg.sv
// constants, field layout and state type of the two-wire memory/clock front end
// assumes: one 250 MHz clock domain, synchronous active-low reset
package snr_pkg;

	// ========================================================
	// memory slave geometry
	localparam int unsigned SNR_MEM_DEPTH = 8192;
	localparam int unsigned SNR_MEM_AW    = 13;

	// ========================================================
	// clock/alarm special function registers
	localparam int unsigned SNR_SFR_NUM = 15;
	localparam int unsigned SNR_SFR_AW  = 4;
	localparam logic [3:0]  SNR_SFR_CTRL = 4'h0;  // timekeeping control
	localparam logic [3:0]  SNR_SFR_CAL  = 4'h1;  // calibration value
	localparam logic [3:0]  SNR_SFR_PROT = 4'he;  // memory_protect_control
	localparam logic [3:0]  SNR_SFR_LAST = 4'he;
	localparam logic [7:0]  SNR_SFR_RESET = 8'h00;

	// field positions
	localparam int unsigned SNR_CTRL_CAL_BIT  = 2;
	localparam int unsigned SNR_PROT_LOW_BIT  = 3;
	localparam int unsigned SNR_PROT_HIGH_BIT = 4;
	localparam int unsigned SNR_PROT_FSEL_LSB = 5;
	localparam int unsigned SNR_PROT_SQW_BIT  = 7;
	localparam logic [7:0]  SNR_PROT_KEEP_MASK = 8'h18;  // protect bits survive reset while backup is present

	// protect ranges, {high, low}
	localparam logic [1:0] SNR_PROT_NONE    = 2'h0;
	localparam logic [1:0] SNR_PROT_QUARTER = 2'h1;
	localparam logic [1:0] SNR_PROT_HALF    = 2'h2;
	localparam logic [1:0] SNR_PROT_FULL    = 2'h3;

	// ========================================================
	// square-wave divider on the 32.768 kHz time base
	localparam int unsigned SNR_DIV_W       = 15;
	localparam int unsigned SNR_DIV_BIT_4K  = 2;   // 4096 Hz
	localparam int unsigned SNR_DIV_BIT_512 = 5;   // 512 Hz
	localparam int unsigned SNR_DIV_BIT_1   = 14;  // 1 Hz
	localparam logic [1:0]  SNR_FSEL_1HZ    = 2'h0;
	localparam logic [1:0]  SNR_FSEL_512HZ  = 2'h1;
	localparam logic [1:0]  SNR_FSEL_4KHZ   = 2'h2;
	localparam logic [1:0]  SNR_FSEL_32KHZ  = 2'h3;

	// ========================================================
	// two-wire slave states
	typedef enum logic [2:0] {
		SNR_ST_IDLE,
		SNR_ST_DEVADDR,
		SNR_ST_RX,
		SNR_ST_ACK,
		SNR_ST_TX,
		SNR_ST_MACK
	} snr_state_t;

endpackage
